// ===== common/fcm_defines.vh
`ifndef FCM_DEFINES_VH
`define FCM_DEFINES_VH
`define FCM_SLOTS 6'd32
`define FCM_LAST_SLOT 5'h1F
`define FCM_LAST_BIT 3'h7
`define FCM_ALIGN_SLOT 5'h00
`define FCM_SIG_SLOT 5'h10
`define FCM_LAST_MF 4'hF
`define FCM_HALF_CHANS 5'd15
`define FCM_CHANS 30
`define FCM_MFAS 4'h0
`define FCM_SPARE_X 1'b1
`define FCM_ABCD_DEF 4'hD
`define FCM_IDLE 8'hFF
`define FCM_MODE_CCS 2'h0
`define FCM_MODE_CAS 2'h1
`define FCM_MODE_CLR 2'h2
`define FCM_MODE_TRIB 2'h3
`define FCM_A_MODE 4'h0
`define FCM_A_ALARM 4'h1
`define FCM_A_SPARE 4'h2
`define FCM_A_TRIBN 4'h3
`define FCM_A_STAT 4'h4
`define FCM_A_MASK 4'h5
`define FCM_A_RXMF 4'h6
`define FCM_A_ABCDU 4'h7
`define FCM_A_ALIGN 4'h8
`define FCM_EV_TXMF 0
`define FCM_EV_RXMF 1
`define FCM_EV_LOSS 2
`define FCM_EV_RXAL 3
`define FCM_NEV 4
`endif

// ===== core/fcm_framer.v
// Functional notes
// - Frame is 256 bits, slots 0..31 ascending
// - Eight bits per slot, bit 1 first
// - Channels 1..30 map to slots skipping 16
// - Slot 16 selectable as plain channel
// - Common-channel mode passes slot 16 transparently
// - Sixteen frames form a signalling multiframe
// - Frame 0 slot 16 bits 1-4 are 0000
// - Spare bits 5,7,8 sent from the spare register, ones at reset
// - Bit 6 carries remote alarm to far end
// - Frame k carries channels k and k+15
// - Four abcd bits per channel per multiframe
// - Unused b,c,d default to 1,0,1
// - Tributary mode keeps slots 0 and 16
// - Width up to 15 fills slots 1..n
// - Wider tributary skips slot 16 to n+1
// - Unassigned tributary slots sent as ones
`include "fcm_defines.vh"
`default_nettype none
module fcm_framer #(
    parameter TRIB_N_DEF = 5'd30
) (
    input wire clk_sys,
    input wire rst_b,
    input wire bit_en,
    input wire [7:0] tx_align_octet,
    input wire [7:0] tx_chan_octet,
    input wire [3:0] tx_chan_abcd,
    input wire [7:0] tx_ccs_octet,
    output wire [4:0] tx_chan_sel,
    output wire tx_chan_take,
    output wire tx_ccs_take,
    output wire tx_trib_take,
    output reg tx_line,
    output wire tx_frame_start,
    input wire rx_line,
    input wire rx_frame_start,
    output reg [7:0] rx_octet,
    output reg [4:0] rx_octet_slot,
    output reg rx_octet_valid,
    output reg [4:0] rx_abcd_chan,
    output reg [3:0] rx_abcd,
    output reg rx_abcd_valid,
    output reg rx_mf_locked,
    output reg [3:0] rx_mf_num,
    input wire [3:0] reg_addr,
    input wire [7:0] reg_wdata,
    input wire reg_wr,
    input wire reg_rd,
    output reg [7:0] reg_rdata,
    output wire irq
);
    reg [1:0] mode_reg;
    reg tx_alarm_reg;
    reg [2:0] spare_reg;
    reg [4:0] trib_n_reg;
    reg [3:0] abcd_used_reg;
    reg [`FCM_NEV-1:0] stat_reg;
    reg [`FCM_NEV-1:0] stat_next;
    reg [`FCM_NEV-1:0] mask_reg;
    reg [4:0] tx_slot_reg;
    reg [2:0] tx_bit_reg;
    reg [3:0] tx_mf_reg;
    reg [7:0] tx_shift_reg;
    reg [7:0] tx_octet_next;
    reg [4:0] tx_chan_next;
    reg tx_is_trib;
    reg [3:0] sig_store_reg [0:`FCM_CHANS-1];
    reg [4:0] rx_slot_reg;
    reg [2:0] rx_bit_reg;
    reg [7:0] rx_shift_reg;
    reg [3:0] rx_mf_reg;
    reg rx_locked_reg;
    reg rx_pend_reg;
    reg [3:0] rx_pend_nib_reg;
    reg [4:0] rx_pend_chan_reg;
    wire rx_octet_end;
    wire rx_sig_octet;
    wire [4:0] rx_second_chan;
    wire [3:0] tx_sig_lo_idx;
    wire [4:0] tx_sig_hi_idx;
    wire [7:0] rx_byte_w;
    wire tx_octet_end;
    wire [4:0] next_slot;
    wire [3:0] tx_mf_next;
    reg [3:0] abcd_fixed;
    genvar g;

    assign tx_octet_end = bit_en && (tx_bit_reg == `FCM_LAST_BIT);
    assign next_slot = tx_slot_reg + 5'h01;
    assign tx_mf_next = (tx_slot_reg == `FCM_LAST_SLOT) ? tx_mf_reg + 4'h1 : tx_mf_reg;
    assign tx_frame_start = tx_octet_end && (tx_slot_reg == `FCM_LAST_SLOT);
    assign irq = |(stat_reg & mask_reg);
    // Store index of channel k and of channel k+15 for frame k
    assign tx_sig_lo_idx = tx_mf_next - 4'h1;
    assign tx_sig_hi_idx = {1'b0, tx_mf_next} + `FCM_HALF_CHANS - 5'h01;

    // Channel number of next slot; slot 16 gives 16, the same number as slot 17
    always @* begin
        if (next_slot > `FCM_SIG_SLOT) begin
            tx_chan_next = next_slot - 5'h01;
        end else begin
            tx_chan_next = next_slot;
        end
    end
    assign tx_chan_sel = tx_chan_next;

    // Tributary slot assignment for the next slot
    always @* begin
        tx_is_trib = 1'b0;
        if (next_slot != `FCM_ALIGN_SLOT && next_slot != `FCM_SIG_SLOT) begin
            if (trib_n_reg <= `FCM_HALF_CHANS) begin
                tx_is_trib = (next_slot <= trib_n_reg);
            end else begin
                tx_is_trib = (next_slot <= trib_n_reg + 5'h01);
            end
        end
    end

    assign tx_chan_take = tx_octet_end && (mode_reg != `FCM_MODE_TRIB) && next_slot != `FCM_ALIGN_SLOT &&
        (next_slot != `FCM_SIG_SLOT || mode_reg == `FCM_MODE_CLR);
    assign tx_ccs_take = tx_octet_end && next_slot == `FCM_SIG_SLOT &&
        (mode_reg == `FCM_MODE_CCS || mode_reg == `FCM_MODE_TRIB);
    assign tx_trib_take = tx_octet_end && (mode_reg == `FCM_MODE_TRIB) && tx_is_trib;

    // Unused b,c,d positions replaced by defaults
    always @* begin
        abcd_fixed = (tx_chan_abcd & abcd_used_reg) | (`FCM_ABCD_DEF & ~abcd_used_reg);
    end

    // One signalling nibble per channel, refreshed when its slot is fetched
    generate
        for (g = 0; g < `FCM_CHANS; g = g + 1) begin : g_sig
            localparam [4:0] CH = g + 1;
            always @(posedge clk_sys or negedge rst_b) begin
                if (!rst_b) begin
                    sig_store_reg[g] <= `FCM_ABCD_DEF;
                end else if (tx_chan_take && next_slot != `FCM_SIG_SLOT && tx_chan_next == CH) begin
                    sig_store_reg[g] <= abcd_fixed;
                end
            end
        end
    endgenerate

    // Octet selected for the next slot
    always @* begin
        tx_octet_next = `FCM_IDLE;
        if (next_slot == `FCM_ALIGN_SLOT) begin
            tx_octet_next = tx_align_octet;
        end else if (next_slot == `FCM_SIG_SLOT) begin
            case (mode_reg)
                `FCM_MODE_CAS: begin
                    if (tx_mf_next == 4'h0) begin
                        tx_octet_next = {`FCM_MFAS, spare_reg[2], tx_alarm_reg, spare_reg[1:0]};
                    end else begin
                        tx_octet_next = {sig_store_reg[tx_sig_lo_idx],
                            sig_store_reg[tx_sig_hi_idx]};
                    end
                end
                `FCM_MODE_CLR: tx_octet_next = tx_chan_octet;
                default: tx_octet_next = tx_ccs_octet;
            endcase
        end else if (mode_reg == `FCM_MODE_TRIB) begin
            tx_octet_next = tx_is_trib ? tx_chan_octet : `FCM_IDLE;
        end else begin
            tx_octet_next = tx_chan_octet;
        end
    end

    always @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            tx_slot_reg <= 5'h00;
            tx_bit_reg <= 3'h0;
            tx_mf_reg <= 4'h0;
            tx_shift_reg <= `FCM_IDLE;
            tx_line <= 1'b1;
        end else begin
            if (bit_en) begin
                tx_bit_reg <= tx_bit_reg + 3'h1;
                if (tx_octet_end) begin
                    tx_slot_reg <= next_slot;
                    tx_mf_reg <= tx_mf_next;
                    tx_shift_reg <= {tx_octet_next[6:0], 1'b1};
                    tx_line <= tx_octet_next[7];
                end else begin
                    tx_shift_reg <= {tx_shift_reg[6:0], 1'b1};
                    tx_line <= tx_shift_reg[7];
                end
            end
        end
    end

    // Receive side: deserialise, align multiframe, split nibbles
    assign rx_byte_w = {rx_shift_reg[6:0], rx_line};
    assign rx_octet_end = bit_en && !rx_frame_start && (rx_bit_reg == `FCM_LAST_BIT);
    assign rx_sig_octet = rx_octet_end && (rx_slot_reg == `FCM_SIG_SLOT) && (mode_reg == `FCM_MODE_CAS);
    assign rx_second_chan = {1'b0, rx_mf_reg} + `FCM_HALF_CHANS;

    // Bit and slot counters, restarted by the far end frame mark
    always @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            rx_slot_reg <= 5'h00;
            rx_bit_reg <= 3'h0;
            rx_shift_reg <= 8'h00;
        end else if (bit_en) begin
            rx_shift_reg <= rx_byte_w;
            if (rx_frame_start) begin
                rx_bit_reg <= 3'h1;
                rx_slot_reg <= `FCM_ALIGN_SLOT;
            end else begin
                rx_bit_reg <= rx_bit_reg + 3'h1;
                if (rx_bit_reg == `FCM_LAST_BIT) begin
                    rx_slot_reg <= rx_slot_reg + 5'h01;
                end
            end
        end
    end

    // Whole received octet with its slot number
    always @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            rx_octet <= 8'h00;
            rx_octet_slot <= 5'h00;
            rx_octet_valid <= 1'b0;
        end else begin
            rx_octet_valid <= 1'b0;
            if (rx_octet_end) begin
                rx_octet <= rx_byte_w;
                rx_octet_slot <= rx_slot_reg;
                rx_octet_valid <= 1'b1;
            end
        end
    end

    // Multiframe alignment and frame counter
    always @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            rx_mf_reg <= 4'h0;
            rx_locked_reg <= 1'b0;
            rx_mf_num <= 4'h0;
            rx_mf_locked <= 1'b0;
        end else begin
            if (rx_sig_octet && rx_byte_w[7:4] == `FCM_MFAS) begin
                rx_mf_reg <= 4'h0;
                rx_locked_reg <= 1'b1;
                rx_mf_num <= 4'h0;
            end else begin
                if (rx_octet_end && rx_slot_reg == `FCM_LAST_SLOT) begin
                    rx_mf_reg <= rx_mf_reg + 4'h1;
                end
                if (rx_sig_octet) begin
                    if (rx_mf_reg == 4'h0) begin
                        // Expected frame 0 without the pattern
                        rx_locked_reg <= 1'b0;
                    end else if (rx_locked_reg) begin
                        rx_mf_num <= rx_mf_reg;
                    end
                end
            end
            rx_mf_locked <= rx_locked_reg;
        end
    end

    // Channel k nibble now, channel k+15 nibble one cycle later
    always @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            rx_abcd_chan <= 5'h00;
            rx_abcd <= 4'h0;
            rx_abcd_valid <= 1'b0;
            rx_pend_reg <= 1'b0;
            rx_pend_nib_reg <= 4'h0;
            rx_pend_chan_reg <= 5'h00;
        end else begin
            rx_abcd_valid <= 1'b0;
            rx_pend_reg <= 1'b0;
            if (rx_pend_reg) begin
                rx_abcd_valid <= 1'b1;
                rx_abcd_chan <= rx_pend_chan_reg;
                rx_abcd <= rx_pend_nib_reg;
            end
            if (rx_sig_octet && rx_locked_reg && rx_mf_reg != 4'h0 && rx_byte_w[7:4] != `FCM_MFAS) begin
                rx_abcd_valid <= 1'b1;
                rx_abcd_chan <= {1'b0, rx_mf_reg};
                rx_abcd <= rx_byte_w[7:4];
                rx_pend_reg <= 1'b1;
                rx_pend_nib_reg <= rx_byte_w[3:0];
                rx_pend_chan_reg <= rx_second_chan;
            end
        end
    end

    // Register bank, sticky status cleared by writing one
    always @* begin
        stat_next = stat_reg;
        if (reg_wr && reg_addr == `FCM_A_STAT) begin
            stat_next = stat_reg & ~reg_wdata[`FCM_NEV-1:0];
        end
        if (tx_frame_start && tx_mf_reg == `FCM_LAST_MF) begin
            stat_next[`FCM_EV_TXMF] = 1'b1;
        end
        if (rx_locked_reg && !rx_mf_locked) begin
            stat_next[`FCM_EV_RXMF] = 1'b1;
        end
        if (!rx_locked_reg && rx_mf_locked) begin
            stat_next[`FCM_EV_LOSS] = 1'b1;
        end
        if (rx_octet_valid && rx_octet_slot == `FCM_SIG_SLOT && rx_mf_num == 4'h0 && rx_octet[2] &&
            mode_reg == `FCM_MODE_CAS) begin
            stat_next[`FCM_EV_RXAL] = 1'b1;
        end
    end

    // Status and mask; an event in the clearing cycle survives
    always @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            stat_reg <= {`FCM_NEV{1'b0}};
            mask_reg <= {`FCM_NEV{1'b0}};
        end else begin
            stat_reg <= stat_next;
            if (reg_wr && reg_addr == `FCM_A_MASK) begin
                mask_reg <= reg_wdata[`FCM_NEV-1:0];
            end
        end
    end

    // Configuration writes
    always @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            mode_reg <= `FCM_MODE_CAS;
            tx_alarm_reg <= 1'b0;
            spare_reg <= {3{`FCM_SPARE_X}};
            trib_n_reg <= TRIB_N_DEF;
            abcd_used_reg <= 4'hF;
        end else if (reg_wr) begin
            case (reg_addr)
                `FCM_A_MODE: mode_reg <= reg_wdata[1:0];
                `FCM_A_ALARM: tx_alarm_reg <= reg_wdata[0];
                `FCM_A_SPARE: spare_reg <= reg_wdata[2:0];
                `FCM_A_TRIBN: trib_n_reg <= reg_wdata[4:0];
                `FCM_A_ABCDU: abcd_used_reg <= reg_wdata[3:0] | 4'h8;
                default: ;
            endcase
        end
    end

    // Read data stands only in the cycle after the read strobe
    always @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            reg_rdata <= 8'h00;
        end else begin
            reg_rdata <= 8'h00;
            if (reg_rd) begin
                case (reg_addr)
                    `FCM_A_MODE: reg_rdata <= {6'h00, mode_reg};
                    `FCM_A_ALARM: reg_rdata <= {7'h00, tx_alarm_reg};
                    `FCM_A_SPARE: reg_rdata <= {5'h00, spare_reg};
                    `FCM_A_TRIBN: reg_rdata <= {3'h0, trib_n_reg};
                    `FCM_A_STAT: reg_rdata <= {4'h0, stat_reg};
                    `FCM_A_MASK: reg_rdata <= {4'h0, mask_reg};
                    `FCM_A_RXMF: reg_rdata <= {3'h0, rx_mf_locked, rx_mf_num};
                    `FCM_A_ABCDU: reg_rdata <= {4'h0, abcd_used_reg};
                    default: reg_rdata <= 8'h00;
                endcase
            end
        end
    end
endmodule
`default_nettype wire

// ===== sim/fcm_framer_checker.sv
`default_nettype none
module fcm_chk (
    input wire logic clk_sys,
    input wire logic rst_b,
    input wire logic bit_en,
    input wire logic tx_chan_take,
    input wire logic tx_ccs_take,
    input wire logic tx_trib_take,
    input wire logic tx_line,
    input wire logic tx_frame_start,
    input wire logic [4:0] rx_abcd_chan,
    input wire logic rx_abcd_valid,
    input wire logic reg_rd,
    input wire logic [7:0] reg_rdata
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] bc;
    logic sy;
    // Line bit index within the frame, valid once the first frame start is seen
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            bc <= 8'h00;
            sy <= 1'b0;
        end else if (bit_en) begin
            bc <= tx_frame_start ? 8'h00 : bc + 8'h01;
            sy <= sy | tx_frame_start;
        end
    end
    default clocking dcb @(posedge clk_sys); endclocking
    default disable iff (!rst_b);
    a_take_one_hot: assert property ($onehot0({tx_chan_take, tx_ccs_take, tx_trib_take}))
        else $error("two take pulses together");
    a_frame_period: assert property (tx_frame_start |-> bit_en && (!sy || bc == 8'hFF))
        else $error("frame length wrong");
    a_take_last_bit: assert property (tx_chan_take || tx_ccs_take || tx_trib_take
        |-> bit_en && (!sy || bc[2:0] == 3'h7)) else $error("take off slot end");
    a_line_on_bit: assert property ($changed(tx_line) |-> $past(bit_en))
        else $error("line moved without bit enable");
    a_ccs_slot_only: assert property (tx_ccs_take && sy |-> bc[7:3] == 5'h0F)
        else $error("slot 16 octet taken elsewhere");
    a_trib_skip_slots: assert property (tx_trib_take && sy |-> bc[7:3] != 5'h0F && bc[7:3] != 5'h1F)
        else $error("tributary in reserved slot");
    a_abcd_pair: assert property (rx_abcd_valid && rx_abcd_chan <= 5'h0F
        |=> rx_abcd_valid && rx_abcd_chan == $past(rx_abcd_chan) + 5'h0F) else $error("abcd pair broken");
    a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
        else $error("read data outside read cycle");
endmodule
bind fcm_framer fcm_chk u_chk (.*);
`default_nettype wire

// ===== sim/fcm_peer.sv
`default_nettype none
module fcm_peer (
    input wire logic clk_sys,
    input wire logic rst_b,
    input wire logic bit_en,
    input wire logic tx_line,
    input wire logic tx_frame_start,
    output logic rx_line,
    output logic rx_frame_start
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] slot_q [0:31];
    logic [7:0] sh, pos;
    logic pend, sy;
    int frames;
    wire logic [7:0] idx = rx_frame_start ? 8'h00 : pos + 8'h01;
    wire logic [7:0] nsh = {sh[6:0], tx_line};
    // Far end loops the line back and marks bit 1 of slot 0
    assign rx_line = tx_line;
    assign rx_frame_start = bit_en & pend;
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            pend <= 1'b0;
            sy <= 1'b0;
            pos <= 8'h00;
            frames <= 0;
        end else if (bit_en) begin
            pend <= tx_frame_start;
            sy <= sy | pend;
            pos <= idx;
            sh <= nsh;
            if (idx[2:0] == 3'h7) slot_q[idx[7:3]] <= nsh;
            if (sy && idx == 8'hFF) frames <= frames + 1;
        end
    end
endmodule
`default_nettype wire

// ===== sim/tb.sv
`default_nettype none
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_sys = 1'b0, rst_b = 1'b0, bit_en = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
    logic [7:0] tx_chan_octet = 8'h00, reg_wdata = 8'h00, reg_rdata, rx_octet, rd_v;
    logic [4:0] tx_chan_sel, rx_octet_slot, rx_abcd_chan;
    logic [3:0] tx_chan_abcd = 4'h8, reg_addr = 4'h0, rx_abcd, rx_mf_num, k = 4'h0;
    logic tx_line, tx_frame_start, rx_line, rx_frame_start, rx_octet_valid, rx_abcd_valid, rx_mf_locked, irq;
    logic [1:0] md = 2'h1;
    logic ua = 1'b0, y = 1'b0, rxc = 1'b0, seen = 1'b0;
    int errors = 0, check_count = 0, cyc = 0, tn = 30;
    fcm_framer DUT (.*, .tx_align_octet(8'h1B), .tx_ccs_octet(8'h3C), .tx_chan_take(), .tx_ccs_take(),
        .tx_trib_take());
    fcm_peer peer (.*);
    initial begin
        forever #4 clk_sys = ~clk_sys;
    end
    always @(posedge clk_sys) begin
        cyc <= cyc + 1;
        bit_en <= cyc % 4 == 3;
        tx_chan_octet <= {3'h0, tx_chan_sel};
        tx_chan_abcd <= {1'b1, tx_chan_sel[2:0]};
        if (cyc == 80000) begin
            errors++;
            give_verdict();
        end
    end
    task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
        check_count++;
        if (g !== e) begin
            errors++;
            $display("mismatch %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic give_verdict();
        $display("errors %0d checks %0d", errors, check_count);
        if (errors == 0 && check_count > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
        #1;
    endtask
    task automatic rd(input logic [3:0] a);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk_sys);
        reg_rd <= 1'b0;
        #1;
        rd_v = reg_rdata;
    endtask
    function automatic logic [3:0] nib(input logic [4:0] c);
        return ua ? {1'b1, c[2:0]} : 4'hD;
    endfunction
    function automatic logic [4:0] chan(input logic [4:0] s);
        return s < 5'h10 ? s : s - 5'h01;
    endfunction
    // First frame after a change is mixed, so it only advances the frame count
    task automatic frames(input int n);
        logic [7:0] e, g;
        int f0;
        for (int i = 0; i < n; i++) begin
            f0 = peer.frames;
            while (peer.frames == f0) @(posedge clk_sys);
            #1;
            k = k + 4'h1;
            if (!seen && peer.slot_q[16][7:4] == 4'h0) begin
                seen = 1'b1;
                k = 4'h0;
            end
            for (int s = 0; s < 32 && i > 0; s++) begin
                g = peer.slot_q[s];
                if (s == 0) e = 8'h1B;
                else if (s == 16 && md != 2'h1) e = md == 2'h2 ? 8'h10 : 8'h3C;
                else if (s == 16) e = k == 4'h0 ? {5'h01, y, 2'h3} : {nib({1'b0, k}), nib(k + 5'h0F)};
                else if (md != 2'h3) e = {3'h0, chan(5'(s))};
                else if (s <= tn + (tn > 15)) e = {3'h0, chan(5'(s))};
                else e = 8'hFF;
                chk("slot", e, g);
            end
        end
    endtask
    always @(negedge clk_sys) begin
        if (rxc && rx_abcd_valid) chk("rx abcd", {4'h0, nib(rx_abcd_chan)}, {4'h0, rx_abcd});
        if (rxc && rx_abcd_valid && rx_abcd_chan < 5'h10)
            chk("rx mf num", {4'h0, rx_abcd_chan[3:0]}, {4'h0, rx_mf_num});
        if (rxc && rx_octet_valid && rx_octet_slot != 5'h00 && rx_octet_slot != 5'h10)
            chk("rx octet", {3'h0, chan(rx_octet_slot)}, rx_octet);
    end
    initial begin
        repeat (3) @(posedge clk_sys);
        rst_b <= 1'b1;
        rd(4'h0);
        chk("mode", 8'h01, rd_v);
        rd(4'h2);
        chk("spare", 8'h07, rd_v);
        rd(4'h3);
        chk("trib n", 8'h1E, rd_v);
        rd(4'hF);
        chk("unmapped", 8'h00, rd_v);
        wr(4'h7, 8'hFF);
        ua = 1'b1;
        frames(18);
        chk("locked", 8'h01, {7'h0, rx_mf_locked});
        rxc = 1'b1;
        frames(3);
        rxc = 1'b0;
        rd(4'h4);
        chk("lock event", 8'h03, rd_v & 8'h03);
        wr(4'h5, 8'h02);
        chk("irq on", 8'h01, {7'h0, irq});
        wr(4'h4, 8'h02);
        chk("irq off", 8'h00, {7'h0, irq});
        wr(4'h7, 8'h00);
        wr(4'h1, 8'h01);
        ua = 1'b0;
        y = 1'b1;
        frames(18);
        rd(4'h4);
        chk("far alarm", 8'h08, rd_v & 8'h08);
        md = 2'h0;
        wr(4'h0, 8'h00);
        frames(2);
        md = 2'h2;
        wr(4'h0, 8'h02);
        frames(2);
        md = 2'h3;
        wr(4'h0, 8'h03);
        for (int j = 0; j < 4; j++) begin
            tn = j == 0 ? 2 : j == 1 ? 15 : j == 2 ? 16 : 30;
            wr(4'h3, 8'(tn));
            frames(2);
        end
        give_verdict();
    end
endmodule
`default_nettype wire
